// [design/gppc_top.sv]
// GPIO port pin control: masked data access, pin configuration, lock and interrupts.
`timescale 1ns/1ns
module gppc_top (
	input wire logic clk, // System clock, 125 MHz.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire gppc_pkg::gppc_acc_t acc, // Data access with mask in address.
	output logic [gppc_pkg::NPINS-1:0] rd_data, // Masked read data.
	output logic rd_valid, // Read data valid pulse.
	input wire gppc_pkg::gppc_cfg_wr_t cfg_wr, // Configuration write.
	input wire logic [2:0] pin_index, // Pin whose settings are read back.
	output gppc_pkg::gppc_pin_cfg_t cfg_rd, // Settings of the indexed pin.
	input wire logic lock_wr, // Lock key write strobe.
	input wire logic [gppc_pkg::KEY_W-1:0] lock_key, // Lock key value.
	input wire logic commit_wr, // Commit mask write strobe.
	input wire logic [gppc_pkg::NPINS-1:0] commit_mask, // Commit mask value.
	output logic lock_open, // Lock currently opened.
	output logic [gppc_pkg::NPINS-1:0] pin_commit_reg, // Pins open to change.
	output gppc_pkg::gppc_pin_cfg_t [gppc_pkg::NPINS-1:0] pad_cfg, // Pad settings.
	input wire logic [gppc_pkg::NPINS-1:0] pin_in, // Pin levels.
	output logic [gppc_pkg::NPINS-1:0] pin_out, // Pin output value.
	output logic [gppc_pkg::NPINS-1:0] pin_oe, // Pin output enable, high drives.
	input wire logic [gppc_pkg::NPERIPH-1:0] periph_out, // Peripheral outputs.
	input wire logic [gppc_pkg::NPERIPH-1:0] periph_oe, // Peripheral enables.
	output logic [gppc_pkg::NPERIPH-1:0] periph_in, // Pin levels to peripherals.
	output logic [gppc_pkg::NPINS-1:0] int_raw, // Raw interrupt status.
	output logic [gppc_pkg::NPINS-1:0] int_masked, // Enabled interrupt status.
	output logic irq // Port interrupt to processor.
);
	import gppc_pkg::*;

	gppc_state_t s_reg;
	gppc_state_t s_next;
	logic [NPINS-1:0] event_hit;
	logic [NPINS-1:0] prev_seen;

	// Until one real sample has been taken the previous level is the present one.
	// This keeps a pin that idles high from showing a false rise after reset.
	assign prev_seen = s_reg.armed ? s_reg.prev_in : pin_in; // R3

	// Guarded kinds touch direction, pad or function; interrupt kinds stay free.
	function automatic logic cfg_allowed(input gppc_cfg_kind_t kind, input logic committed);
		logic guarded;
		guarded = (kind == CFG_DIR) || (kind == CFG_DRIVE) || (kind == CFG_SLEW) ||
			(kind == CFG_PULL) || (kind == CFG_OD) || (kind == CFG_PMUX);
		return !guarded || committed; // R12
	endfunction

	// Pin mask carried in the address of a data access.
	function automatic logic [NPINS-1:0] addr_mask(input logic [ADDR_W-1:0] addr);
		return addr[ADDR_MASK_LSB +: NPINS]; // R11
	endfunction

	// True when a pin is handed to the peripheral that drives signal k.
	function automatic logic routes_to(input gppc_pin_cfg_t c, input int k);
		return (c.dir == DIR_HW) && (c.pmux == k[1:0]); // R13
	endfunction

	gppc_irq_detect u_detect (
		.pin_in(pin_in),
		.prev_in(prev_seen),
		.cfg(s_reg.cfg),
		.event_hit(event_hit)
	);

	// Next state: configuration, lock, data, interrupts and pin drive.
	always_comb begin
		logic [NPINS-1:0] m;
		logic [NPINS-1:0] clr;
		gppc_pin_cfg_t c;
		m = addr_mask(acc.addr);
		clr = '0;
		c = PIN_CFG_RST;
		s_next = s_reg;
		s_next.rd_valid = 1'b0;
		s_next.prev_in = pin_in;
		s_next.armed = 1'b1;

		// Any key other than the right one closes the lock again.
		if (lock_wr) begin
			s_next.lock_open = (lock_key == UNLOCK_KEY); // R16
		end
		// Commit only takes while open; unguarded pins always stay committed.
		if (commit_wr && s_reg.lock_open) begin
			s_next.commit = commit_mask | ~LOCKABLE_MASK; // R12
		end

		// Configuration write applies at once to every selected pin that the lock allows.
		for (int i = 0; i < NPINS; i++) begin
			c = s_reg.cfg[i];
			if (cfg_wr.valid && cfg_wr.pins[i] && cfg_allowed(cfg_wr.kind, s_reg.commit[i])) begin // R1
				unique case (cfg_wr.kind)
					CFG_DIR: begin
						if (cfg_wr.value[1:0] == DIR_OUT) begin
							c.dir = DIR_OUT; // R2
						end else if (cfg_wr.value[1:0] == DIR_HW && HAS_ALT_MASK[i]) begin
							c.dir = DIR_HW; // R14
						end else begin
							c.dir = DIR_IN; // R8
						end
					end
					CFG_DRIVE: begin
						if (cfg_wr.value[1:0] == DRV_8MA) begin
							c.drive = DRV_8MA; // R4
						end else if (cfg_wr.value[1:0] == DRV_4MA) begin
							c.drive = DRV_4MA; // R4
						end else begin
							c.drive = DRV_2MA; // R4
						end
					end
					CFG_SLEW: c.slew = cfg_wr.value[0]; // R4
					CFG_PULL: begin
						if (cfg_wr.value[1:0] == PULL_UP) begin
							c.pull = PULL_UP; // R5
						end else if (cfg_wr.value[1:0] == PULL_DOWN) begin
							c.pull = PULL_DOWN; // R5
						end else begin
							c.pull = PULL_NONE; // R5
						end
					end
					CFG_OD: c.od = cfg_wr.value[0]; // R6
					CFG_ITYPE: begin
						unique case (cfg_wr.value)
							3'h0: c.itype = IT_HIGH;
							3'h1: c.itype = IT_LOW;
							3'h2: c.itype = IT_RISE;
							3'h3: c.itype = IT_FALL;
							default: c.itype = IT_BOTH;
						endcase
					end
					CFG_IEN: c.ien = cfg_wr.value[0]; // R15
					CFG_PMUX: c.pmux = cfg_wr.value[1:0]; // R13
					CFG_ICLR: clr[i] = 1'b1; // R18
					default: c = s_reg.cfg[i];
				endcase
			end
			// Slew limiting only means something at the strongest drive.
			if (c.drive != DRV_8MA) begin
				c.slew = 1'b0; // R4
			end
			s_next.cfg[i] = c;
		end

		// Data write changes every masked pin in the same cycle.
		if (acc.valid && acc.write) begin
			s_next.data = (s_reg.data & ~m) | (acc.wdata & m); // R10
		end
		// Data read shows masked pins only; the rest read as zero.
		if (acc.valid && !acc.write) begin
			s_next.rd_data = pin_in & m; // R9 R17
			s_next.rd_valid = 1'b1;
		end

		// A new event wins over a clear arriving in the same cycle.
		s_next.raw = (s_reg.raw & ~clr) | event_hit; // R18
		for (int i = 0; i < NPINS; i++) begin
			s_next.masked[i] = s_next.raw[i] & s_next.cfg[i].ien; // R18
		end
		s_next.irq = |s_next.masked; // R15

		s_next.cfg_rd = s_next.cfg[pin_index]; // R1

		// Pin drive follows the chosen control; open drain only pulls low.
		for (int i = 0; i < NPINS; i++) begin
			logic v;
			logic en;
			v = 1'b0;
			en = 1'b0;
			unique case (s_next.cfg[i].dir)
				DIR_OUT: begin
					v = s_next.data[i]; // R14
					en = 1'b1;
				end
				DIR_HW: begin
					v = periph_out[s_next.cfg[i].pmux]; // R13
					en = periph_oe[s_next.cfg[i].pmux]; // R14
				end
				default: begin
					v = 1'b0; // R2
					en = 1'b0;
				end
			endcase
			if (s_next.cfg[i].od) begin
				s_next.pin_out[i] = 1'b0; // R6
				s_next.pin_oe[i] = en & ~v; // R6
			end else begin
				s_next.pin_out[i] = v;
				s_next.pin_oe[i] = en;
			end
		end

		// Peripheral inputs: highest routed pin wins when several select one.
		for (int k = 0; k < NPERIPH; k++) begin
			s_next.periph_in[k] = 1'b0;
			for (int i = 0; i < NPINS; i++) begin
				if (routes_to(s_next.cfg[i], k)) begin
					s_next.periph_in[k] = pin_in[i]; // R13
				end
			end
		end
	end

	// All state registers together; reset puts every pin back to plain input.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_reg.cfg <= {NPINS{PIN_CFG_RST}}; // R2 R4 R5 R6 R7
			s_reg.data <= DATA_RST;
			s_reg.commit <= COMMIT_RST; // R12
			s_reg.lock_open <= 1'b0;
			s_reg.prev_in <= '0;
			s_reg.armed <= 1'b0;
			s_reg.raw <= '0;
			s_reg.masked <= '0;
			s_reg.irq <= 1'b0;
			s_reg.rd_data <= '0;
			s_reg.rd_valid <= 1'b0;
			s_reg.cfg_rd <= PIN_CFG_RST;
			s_reg.pin_out <= '0;
			s_reg.pin_oe <= '0;
			s_reg.periph_in <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs are taken straight from the state flops.
	assign rd_data = s_reg.rd_data;
	assign rd_valid = s_reg.rd_valid;
	assign cfg_rd = s_reg.cfg_rd;
	assign lock_open = s_reg.lock_open;
	assign pin_commit_reg = s_reg.commit;
	assign pad_cfg = s_reg.cfg;
	assign pin_out = s_reg.pin_out;
	assign pin_oe = s_reg.pin_oe;
	assign periph_in = s_reg.periph_in;
	assign int_raw = s_reg.raw;
	assign int_masked = s_reg.masked;
	assign irq = s_reg.irq;
endmodule

// [design/gppc_pkg.sv]
// Constants, types and state layout shared by the GPIO port pin control block.
// Notes on behaviour
// R1: Eight pins; mask bit n selects pin n; a single pin index runs 0 to 7.
// R2: Each pin is input or output; every pin resets to input.
// R3: Input pins raise interrupts on high, low, rising, falling or both edges.
// R4: Drive is 2, 4 or 8 mA, resets to 2 mA; slew only with 8 mA.
// R5: Pull is up, down or none; resets to none.
// R6: Optional open-drain output; resets to push-pull.
// R7: Function is plain GPIO or peripheral; resets to plain GPIO.
// R8: Pins without a peripheral function always behave as plain GPIO.
// R9: A data read returns only the pins chosen by the access mask.
// R10: A data write updates all masked pins together, others unchanged.
// R11: The data access mask comes from address bits of that same access.
// R12: Debug and NMI pins are locked; unlock before changing direction, pad or function.
// R13: Each pin picks which peripheral signal it carries, so one signal reaches many pins.
// R14: Pin control is software input, software output or peripheral hardware.
// R15: Only enabled interrupt sources reach the interrupt output.
// R16: Software unlocks by writing the lock key, then the commit mask.
// R17: Unselected pins read as zero in a masked data read.
// R18: Raw status, masked status as raw AND enable, and write-to-clear per bit.
package gppc_pkg;

	localparam int NPINS = 8;
	localparam int NPERIPH = 4;
	localparam int ADDR_W = 10;
	localparam int ADDR_MASK_LSB = 2;
	localparam int KEY_W = 16;

	// Unlock key value is arbitrary.
	localparam logic [KEY_W-1:0] UNLOCK_KEY = 16'hA5C3;
	// Pins guarded by the lock (debug and NMI capable pins).
	localparam logic [NPINS-1:0] LOCKABLE_MASK = 8'h0F;
	// Pins that own a peripheral function.
	localparam logic [NPINS-1:0] HAS_ALT_MASK = 8'h7F;
	localparam logic [NPINS-1:0] DATA_RST = 8'h00;
	localparam logic [NPINS-1:0] COMMIT_RST = ~LOCKABLE_MASK;

	typedef enum logic [1:0] {DIR_IN, DIR_OUT, DIR_HW} gppc_dir_t;
	typedef enum logic [1:0] {DRV_2MA, DRV_4MA, DRV_8MA} gppc_drive_t;
	typedef enum logic [1:0] {PULL_NONE, PULL_UP, PULL_DOWN} gppc_pull_t;
	typedef enum logic [2:0] {IT_HIGH, IT_LOW, IT_RISE, IT_FALL, IT_BOTH} gppc_itype_t;
	typedef enum logic [3:0] {
		CFG_DIR, CFG_DRIVE, CFG_SLEW, CFG_PULL, CFG_OD,
		CFG_ITYPE, CFG_IEN, CFG_PMUX, CFG_ICLR
	} gppc_cfg_kind_t;

	typedef struct packed {
		gppc_dir_t dir;
		gppc_drive_t drive;
		logic slew;
		gppc_pull_t pull;
		logic od;
		gppc_itype_t itype;
		logic ien;
		logic [1:0] pmux;
	} gppc_pin_cfg_t;

	localparam gppc_pin_cfg_t PIN_CFG_RST = '{
		dir: DIR_IN, drive: DRV_2MA, slew: 1'b0, pull: PULL_NONE,
		od: 1'b0, itype: IT_RISE, ien: 1'b0, pmux: 2'h0
	};

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [NPINS-1:0] wdata;
	} gppc_acc_t;

	typedef struct packed {
		logic valid;
		gppc_cfg_kind_t kind;
		logic [NPINS-1:0] pins;
		logic [2:0] value;
	} gppc_cfg_wr_t;

	typedef struct packed {
		gppc_pin_cfg_t [NPINS-1:0] cfg;
		logic [NPINS-1:0] data;
		logic [NPINS-1:0] commit;
		logic lock_open;
		logic [NPINS-1:0] prev_in;
		logic armed;
		logic [NPINS-1:0] raw;
		logic [NPINS-1:0] masked;
		logic irq;
		logic [NPINS-1:0] rd_data;
		logic rd_valid;
		gppc_pin_cfg_t cfg_rd;
		logic [NPINS-1:0] pin_out;
		logic [NPINS-1:0] pin_oe;
		logic [NPERIPH-1:0] periph_in;
	} gppc_state_t;

endpackage

// [design/gppc_irq_detect.sv]
// Per-pin interrupt condition detector for the GPIO port.
`timescale 1ns/1ns
module gppc_irq_detect (
	input wire logic [gppc_pkg::NPINS-1:0] pin_in, // Current pin levels.
	input wire logic [gppc_pkg::NPINS-1:0] prev_in, // Levels one cycle earlier.
	input wire gppc_pkg::gppc_pin_cfg_t [gppc_pkg::NPINS-1:0] cfg, // Pin settings.
	output logic [gppc_pkg::NPINS-1:0] event_hit // Condition seen this cycle.
);
	import gppc_pkg::*;

	// Each pin compares its level against the previous sample.
	// Only input pins may fire, so driven outputs never interrupt themselves.
	for (genvar i = 0; i < NPINS; i++) begin : g_pin
		logic rise;
		logic fall;
		logic hit;
		assign rise = pin_in[i] & ~prev_in[i];
		assign fall = ~pin_in[i] & prev_in[i];
		always_comb begin
			unique case (cfg[i].itype)
				IT_HIGH: hit = pin_in[i]; // R3
				IT_LOW: hit = ~pin_in[i]; // R3
				IT_RISE: hit = rise; // R3
				IT_FALL: hit = fall; // R3
				IT_BOTH: hit = rise | fall; // R3
				default: hit = 1'b0;
			endcase
		end
		assign event_hit[i] = hit & (cfg[i].dir == DIR_IN); // R3
	end
endmodule

// [sim/gppc_asserts.sv]
// Port checks for the GPIO port pin control block.
`timescale 1ns/1ns
module gppc_asserts (
	input wire logic clk, // Clock.
	input wire logic rst_b, // Reset, active low.
	input wire gppc_pkg::gppc_acc_t acc, // Data access.
	input wire logic [gppc_pkg::NPINS-1:0] rd_data, // Read data.
	input wire logic rd_valid, // Read pulse.
	input wire logic lock_wr, // Key strobe.
	input wire logic [gppc_pkg::KEY_W-1:0] lock_key, // Key value.
	input wire logic lock_open, // Lock state.
	input wire logic commit_wr, // Commit strobe.
	input wire logic [gppc_pkg::NPINS-1:0] pin_commit_reg, // Open pins.
	input wire gppc_pkg::gppc_pin_cfg_t [gppc_pkg::NPINS-1:0] pad_cfg, // Settings.
	input wire logic [gppc_pkg::NPINS-1:0] pin_in, // Pin levels.
	input wire logic [gppc_pkg::NPINS-1:0] pin_oe, // Pin enables.
	input wire logic [gppc_pkg::NPINS-1:0] int_raw, // Raw status.
	input wire logic [gppc_pkg::NPINS-1:0] int_masked, // Masked status.
	input wire logic irq // Port interrupt.
);
	import gppc_pkg::*;
	logic [NPINS-1:0] ien_v, slew_bad, in_oe, hw_bad;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Per-pin views of the settings, so each check spans the whole port.
	always_comb begin
		for (int n = 0; n < NPINS; n++) begin
			ien_v[n] = pad_cfg[n].ien;
			slew_bad[n] = pad_cfg[n].slew && (pad_cfg[n].drive != DRV_8MA);
			in_oe[n] = pin_oe[n] && (pad_cfg[n].dir == DIR_IN);
			hw_bad[n] = (pad_cfg[n].dir == DIR_HW) && !HAS_ALT_MASK[n];
		end
	end
	sequence s_rd;
		acc.valid && !acc.write;
	endsequence
	sequence s_key;
		lock_wr && (lock_key == UNLOCK_KEY);
	endsequence
	property p_rd_pulse;
		s_rd |=> rd_valid;
	endproperty
	property p_rd_only;
		!(acc.valid && !acc.write) |=> !rd_valid;
	endproperty
	property p_rd_data;
		s_rd |=> rd_data == (8'($past(acc.addr) >> 2) & $past(pin_in));
	endproperty
	property p_masked;
		int_masked == (int_raw & ien_v);
	endproperty
	property p_irq;
		irq == (|int_masked);
	endproperty
	property p_slew;
		slew_bad == '0;
	endproperty
	property p_no_alt;
		hw_bad == '0;
	endproperty
	property p_in_oe;
		in_oe == '0;
	endproperty
	property p_open;
		s_key |=> lock_open;
	endproperty
	property p_bad_key;
		lock_wr && (lock_key != UNLOCK_KEY) |=> !lock_open;
	endproperty
	property p_commit;
		!(commit_wr && lock_open) |=> $stable(pin_commit_reg);
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse missing");
	a_rd_only: assert property (p_rd_only) else $error("stray read pulse");
	a_rd_data: assert property (p_rd_data) else $error("masked read wrong");
	a_masked: assert property (p_masked) else $error("masked status wrong");
	a_irq: assert property (p_irq) else $error("interrupt output wrong");
	a_slew: assert property (p_slew) else $error("slew without top drive");
	a_no_alt: assert property (p_no_alt) else $error("hardware mode on plain pin");
	a_in_oe: assert property (p_in_oe) else $error("input pin drives");
	a_open: assert property (p_open) else $error("lock did not open");
	a_bad_key: assert property (p_bad_key) else $error("lock opened by bad key");
	a_commit: assert property (p_commit) else $error("commit changed while locked");
endmodule
bind gppc_top gppc_asserts u_chk (.clk, .rst_b, .acc, .rd_data, .rd_valid, .lock_wr,
	.lock_key, .lock_open, .commit_wr, .pin_commit_reg, .pad_cfg, .pin_in, .pin_oe,
	.int_raw, .int_masked, .irq);

// [sim/gppc_board.sv]
// Board model that resolves the level on each port pin.
`timescale 1ns/1ns
module gppc_board (
	input wire logic [gppc_pkg::NPINS-1:0] pin_out, // Port drive value.
	input wire logic [gppc_pkg::NPINS-1:0] pin_oe, // Port drive enable.
	input wire logic [gppc_pkg::NPINS-1:0] ext_lvl, // Board level.
	input wire logic [gppc_pkg::NPINS-1:0] ext_en, // Board drives pin.
	input wire gppc_pkg::gppc_pin_cfg_t [gppc_pkg::NPINS-1:0] pad_cfg, // Pulls.
	output logic [gppc_pkg::NPINS-1:0] pin_in // Wire levels.
);
	import gppc_pkg::*;
	// A floating pin takes its pull, else the inverse of the port value, never a stale level.
	always_comb begin
		for (int n = 0; n < NPINS; n++) begin
			if (pin_oe[n])
				pin_in[n] = pin_out[n];
			else if (ext_en[n])
				pin_in[n] = ext_lvl[n];
			else if (pad_cfg[n].pull != PULL_NONE)
				pin_in[n] = (pad_cfg[n].pull == PULL_UP);
			else
				pin_in[n] = ~pin_out[n];
		end
	end
endmodule

// [sim/gppc_top_tb_top.sv]
// Self-checking bench for the GPIO port pin control block.
`timescale 1ns/1ns
module gppc_top_tb_top;
	import gppc_pkg::*;
	logic clk = 0, rst_b = 0, lock_wr = 0, commit_wr = 0, rd_valid, lock_open, irq;
	gppc_acc_t acc = '0;
	gppc_cfg_wr_t cfg_wr = '0;
	logic [2:0] pin_index = 3'h0;
	logic [KEY_W-1:0] lock_key = '0;
	logic [NPINS-1:0] commit_mask = '0, ext_lvl = '0, ext_en = '0;
	logic [NPINS-1:0] rd_data, pin_commit_reg, pin_in, pin_out, pin_oe, int_raw, int_masked;
	logic [NPERIPH-1:0] periph_out = '0, periph_oe = '0, periph_in;
	gppc_pin_cfg_t cfg_rd;
	gppc_pin_cfg_t [NPINS-1:0] pad_cfg;
	int n_errors = 0, check_count = 0, cycles = 0;
	gppc_top dut (.clk, .rst_b, .acc, .rd_data, .rd_valid, .cfg_wr, .pin_index, .cfg_rd,
		.lock_wr, .lock_key, .commit_wr, .commit_mask, .lock_open, .pin_commit_reg,
		.pad_cfg, .pin_in, .pin_out, .pin_oe, .periph_out, .periph_oe, .periph_in,
		.int_raw, .int_masked, .irq);
	gppc_board board (.pin_out, .pin_oe, .ext_lvl, .ext_en, .pad_cfg, .pin_in);
	always #4 clk = ~clk;
	// The tests need under a hundred cycles; a hang is cut off well beyond that.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			summarize();
		end
	end
	task summarize;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(logic [31:0] got, logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Drivers act just after an edge and return one step after the taking edge.
	task tick(int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task cfg(gppc_cfg_kind_t k, logic [7:0] p, logic [2:0] v);
		cfg_wr = '{1'b1, k, p, v};
		@(posedge clk) #1 cfg_wr.valid = 1'b0;
	endtask
	task acc_op(logic w, logic [7:0] m, logic [7:0] d);
		acc = '{1'b1, w, {m, 2'b00}, d};
		@(posedge clk) #1 acc.valid = 1'b0;
	endtask
	task unlock(logic [15:0] k, logic [7:0] m);
		lock_wr = 1'b1;
		lock_key = k;
		tick(1);
		lock_wr = 1'b0;
		chk(lock_open, k == UNLOCK_KEY);
		commit_wr = 1'b1;
		commit_mask = m;
		tick(1);
		commit_wr = 1'b0;
	endtask
	task t_reset;
		for (int n = 0; n < NPINS; n++)
			chk(pad_cfg[n], PIN_CFG_RST);
		chk({lock_open, pin_oe, pin_commit_reg}, 17'h000F0);
		tick(1);
		chk(int_raw, 8'h00);
		$display("reset test done");
	endtask
	task t_data;
		cfg(CFG_DIR, 8'hF0, 3'h1);
		acc_op(1'b1, 8'hFF, 8'hA0);
		acc_op(1'b1, 8'h30, 8'h5F);
		ext_en = 8'h0F;
		ext_lvl = 8'h0A;
		tick(1);
		chk({pin_oe, pin_out}, 16'hF090);
		acc_op(1'b0, 8'h3C, 8'hFF);
		chk({rd_valid, rd_data}, 9'h118);
		$display("data test done");
	endtask
	task t_lock;
		cfg(CFG_DIR, 8'h01, 3'h1);
		chk(pad_cfg[0].dir, DIR_IN);
		unlock(16'h1234, 8'h01);
		chk(pin_commit_reg, 8'hF0);
		unlock(UNLOCK_KEY, 8'h01);
		chk(pin_commit_reg, 8'hF1);
		cfg(CFG_DIR, 8'h01, 3'h1);
		chk(pad_cfg[0].dir, DIR_OUT);
		$display("lock test done");
	endtask
	task t_irq;
		gppc_itype_t ty[8] = '{IT_HIGH, IT_LOW, IT_RISE, IT_FALL, IT_BOTH, IT_BOTH, IT_RISE,
			IT_RISE};
		logic [7:0] st = 8'h5A, ie = 8'h7F, ex = 8'hBF;
		for (int i = 0; i < 8; i++) begin
			ext_lvl[2] = st[i];
			cfg(CFG_ITYPE, 8'h04, 3'(ty[i]));
			cfg(CFG_IEN, 8'h04, {2'h0, ie[i]});
			cfg(CFG_ICLR, 8'h04, 3'h0);
			tick(1);
			chk(int_raw[2], 1'b0);
			ext_lvl[2] = ~st[i];
			tick(2);
			chk({irq, int_masked[2], int_raw[2]}, {ie[i] & ex[i], ie[i] & ex[i], ex[i]});
		end
		$display("interrupt test done");
	endtask
	task t_hw;
		periph_out = 4'h4;
		periph_oe = 4'h4;
		cfg(CFG_PMUX, 8'h10, 3'h2);
		cfg(CFG_DIR, 8'h90, 3'h2);
		tick(1);
		chk(pad_cfg[7].dir, DIR_IN);
		chk({pin_oe[4], pin_out[4], periph_in}, 6'h34);
		$display("peripheral test done");
	endtask
	task t_pad;
		gppc_pin_cfg_t e = '{DIR_OUT, DRV_8MA, 1'b1, PULL_UP, 1'b1, IT_RISE, 1'b0, 2'h0};
		pin_index = 3'h5;
		cfg(CFG_DRIVE, 8'h20, 3'h1);
		cfg(CFG_SLEW, 8'h20, 3'h1);
		chk(pad_cfg[5].slew, 1'b0);
		cfg(CFG_DRIVE, 8'h20, 3'h2);
		cfg(CFG_SLEW, 8'h20, 3'h1);
		cfg(CFG_PULL, 8'h20, 3'h1);
		cfg(CFG_OD, 8'h20, 3'h1);
		tick(1);
		chk(cfg_rd, e);
		chk({pin_oe[5], pin_out[5]}, 2'b10);
		cfg(CFG_DRIVE, 8'h20, 3'h0);
		chk(pad_cfg[5].slew, 1'b0);
		$display("pad test done");
	endtask
	// Reset is released just after an edge so the first request meets a clean edge.
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_b = 1'b1;
		t_reset();
		t_data();
		t_lock();
		t_irq();
		t_hw();
		t_pad();
		summarize();
	end
endmodule
